// [core/srls_pkg.sv]
`default_nettype none
package srls_pkg;
	// ********************************
	// Register numbers
	// ********************************
	localparam logic [7:0] REG_NODE_ID = 8'h05;
	localparam logic [7:0] REG_TEST_PORT_IDENTITY = 8'h09;
	localparam logic [7:0] REG_USER_CODE = 8'h0a;
	localparam logic [7:0] REG_DIRECTION_TABLE_LOW = 8'h0c;
	localparam logic [7:0] REG_DIRECTION_TABLE_HIGH = 8'h0d;
	localparam logic [7:0] REG_SPARE_CONTROL_A = 8'h10;
	localparam logic [7:0] REG_SPARE_CONTROL_B = 8'h11;
	localparam logic [7:0] REG_DEBUG_EVENT_ORIGIN = 8'h1f;
	localparam logic [7:0] REG_SYSTEM_LINK_STATE = 8'h20;
	localparam logic [7:0] REG_PROCESSOR_LINK_STATE = 8'h40;
	// ********************************
	// Field masks and reset values
	// ********************************
	localparam logic [31:0] SYS_LINK_WMASK = 32'h00000f30;
	localparam logic [31:0] PROC_LINK_WMASK = 32'h00000030;
	localparam logic [31:0] SPARE_WMASK = 32'h00000003;
	localparam logic [31:0] NODE_ID_WMASK = 32'h0000ffff;
	localparam logic [31:0] TABLE_RESET = 32'h00000000;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam int DIR_W = 4;
	localparam int DIMS = 16;
	localparam int ID_W = 16;
	// Link word field positions
	localparam int KIND_LSB = 24;
	localparam int DEST_LSB = 16;
	localparam int DIR_LSB = 8;
	localparam int NET_LSB = 4;
	localparam int NET_W = 2;
	localparam int JUNK_BIT = 2;
	localparam int DEST_BUSY_BIT = 1;
	localparam int SRC_BUSY_BIT = 0;
	// Identity fields; values arbitrary
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h5a5a;
	localparam logic [10:0] ID_MAKER = 11'h123;
	localparam logic ID_MARK = 1'b1;
	localparam logic [17:0] REVISION_CODE = 18'h00001; // Arbitrary
endpackage
`default_nettype wire

// [core/srls_route_pick.sv]
`timescale 1ns/100ps
`default_nettype none
// Combinational direction selection
module srls_route_pick (
	input wire logic [15:0] destId,
	input wire logic [15:0] nodeId,
	input wire logic [31:0] tableLow,
	input wire logic [31:0] tableHigh,
	output logic isLocal,
	output logic [3:0] direction
);
	// Position of highest set bit
	function automatic logic [3:0] top_bit(input logic [15:0] v);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < srls_pkg::DIMS; i++)
			if (v[i]) p = 4'(i);
		return p;
	endfunction

	logic [15:0] diff;
	logic [3:0] dim;
	logic [63:0] allDirs;

	// Highest mismatch picks the entry
	always_comb
	begin
		diff = destId ^ nodeId;
		isLocal = (diff == 16'h0000);
		dim = top_bit(diff);
		allDirs = {tableHigh, tableLow};
		direction = allDirs[{dim, 2'b00} +: srls_pkg::DIR_W];
	end
endmodule // srls_route_pick
`default_nettype wire

// [core/srls_link_status.sv]
`timescale 1ns/100ps
`default_nettype none
// Builds one link status word
module srls_link_status (
	input wire logic [1:0] srcKind,
	input wire logic [7:0] destLink,
	input wire logic junk,
	input wire logic destBusy,
	input wire logic srcBusy,
	input wire logic [31:0] ctrl,
	output logic [31:0] word
);
	// Destination link only shown while busy
	always_comb
	begin
		word = ctrl;
		word[srls_pkg::KIND_LSB +: 2] = srcKind;
		word[srls_pkg::DEST_LSB +: 8] = (srcBusy | destBusy) ? destLink : 8'h00;
		word[srls_pkg::JUNK_BIT] = junk;
		word[srls_pkg::DEST_BUSY_BIT] = destBusy;
		word[srls_pkg::SRC_BUSY_BIT] = srcBusy;
	end
endmodule // srls_link_status
`default_nettype wire

// [core/srls_switch_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// Register set and routing decision of the packet switch
module srls_switch_regs #(
	parameter int SYS_LINKS = 8,
	parameter int PROC_LINKS = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic cfgWrite,
	input wire logic cfgRead,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgWdata,
	output logic [31:0] cfgRdata,
	output logic cfgRvalid,
	input wire logic [13:0] otpUsercode,
	input wire logic debugEvent,
	input wire logic [31:0] debugSource,
	input wire logic [SYS_LINKS*2-1:0] sysSrcKind,
	input wire logic [SYS_LINKS*8-1:0] sysDestLink,
	input wire logic [SYS_LINKS-1:0] sysJunk,
	input wire logic [SYS_LINKS-1:0] sysDestBusy,
	input wire logic [SYS_LINKS-1:0] sysSrcBusy,
	input wire logic [PROC_LINKS*2-1:0] procSrcKind,
	input wire logic [PROC_LINKS*8-1:0] procDestLink,
	input wire logic [PROC_LINKS-1:0] procJunk,
	input wire logic [PROC_LINKS-1:0] procDestBusy,
	input wire logic [PROC_LINKS-1:0] procSrcBusy,
	input wire logic routeReq,
	input wire logic [15:0] routeDest,
	output logic routeValid,
	output logic routeLocal,
	output logic [3:0] routeDir,
	output logic [SYS_LINKS*4-1:0] sysLinkDir,
	output logic [SYS_LINKS*2-1:0] sysLinkNet,
	output logic [PROC_LINKS*2-1:0] procLinkNet
);
	// ********************************
	// Writable state
	// ********************************
	logic [31:0] nodeId_reg, nodeId_next;
	logic [31:0] tableLow_reg, tableLow_next;
	logic [31:0] tableHigh_reg, tableHigh_next;
	logic [31:0] spareA_reg, spareA_next;
	logic [31:0] spareB_reg, spareB_next;
	logic [31:0] sysCtrl_reg [SYS_LINKS];
	logic [31:0] sysCtrl_next [SYS_LINKS];
	logic [31:0] procCtrl_reg [PROC_LINKS];
	logic [31:0] procCtrl_next [PROC_LINKS];

	// Masked write keeps reserved bits at zero
	function automatic logic [31:0] mwrite(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		return (old & ~m) | (d & m);
	endfunction

	// Control fields sit at the same place in both link banks
	function automatic logic [srls_pkg::DIR_W-1:0] ctrlDir(input logic [31:0] w);
		return w[srls_pkg::DIR_LSB +: srls_pkg::DIR_W];
	endfunction

	function automatic logic [srls_pkg::NET_W-1:0] ctrlNet(input logic [31:0] w);
		return w[srls_pkg::NET_LSB +: srls_pkg::NET_W];
	endfunction

	// ********************************
	// Address decode
	// ********************************
	logic [SYS_LINKS-1:0] sysHit;
	logic [PROC_LINKS-1:0] procHit;

	// Register number lands on slot idx of a link bank
	function automatic logic bankHit(input logic [7:0] addr, input logic [7:0] base,
		input int idx);
		return addr == base + 8'(idx);
	endfunction

	// One decode shared by both paths, so write and read never disagree on a slot
	always_comb
	begin
		for (int i = 0; i < SYS_LINKS; i++)
		begin
			sysHit[i] = bankHit(cfgAddr, srls_pkg::REG_SYSTEM_LINK_STATE, i);
		end
		for (int i = 0; i < PROC_LINKS; i++)
		begin
			procHit[i] = bankHit(cfgAddr, srls_pkg::REG_PROCESSOR_LINK_STATE, i);
		end
	end

	// Config writes, software only path
	always_comb
	begin
		nodeId_next = nodeId_reg;
		tableLow_next = tableLow_reg;
		tableHigh_next = tableHigh_reg;
		spareA_next = spareA_reg;
		spareB_next = spareB_reg;
		for (int i = 0; i < SYS_LINKS; i++) sysCtrl_next[i] = sysCtrl_reg[i];
		for (int i = 0; i < PROC_LINKS; i++) procCtrl_next[i] = procCtrl_reg[i];
		// Writes to read-only numbers fall through and change nothing
		if (cfgWrite)
		begin
			case (cfgAddr)
				srls_pkg::REG_NODE_ID:
					nodeId_next = mwrite(nodeId_reg, cfgWdata, srls_pkg::NODE_ID_WMASK);
				srls_pkg::REG_DIRECTION_TABLE_LOW:
					tableLow_next = cfgWdata;
				srls_pkg::REG_DIRECTION_TABLE_HIGH:
					tableHigh_next = cfgWdata;
				srls_pkg::REG_SPARE_CONTROL_A:
					spareA_next = mwrite(spareA_reg, cfgWdata, srls_pkg::SPARE_WMASK);
				srls_pkg::REG_SPARE_CONTROL_B:
					spareB_next = mwrite(spareB_reg, cfgWdata, srls_pkg::SPARE_WMASK);
				default:
				begin
					for (int i = 0; i < SYS_LINKS; i++)
						if (sysHit[i])
							sysCtrl_next[i] = mwrite(sysCtrl_reg[i], cfgWdata,
								srls_pkg::SYS_LINK_WMASK);
					for (int i = 0; i < PROC_LINKS; i++)
						if (procHit[i])
							procCtrl_next[i] = mwrite(procCtrl_reg[i], cfgWdata,
								srls_pkg::PROC_LINK_WMASK);
				end
			endcase
		end
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			nodeId_reg <= srls_pkg::REG_RESET;
			tableLow_reg <= srls_pkg::TABLE_RESET;
			tableHigh_reg <= srls_pkg::TABLE_RESET;
			spareA_reg <= srls_pkg::REG_RESET;
			spareB_reg <= srls_pkg::REG_RESET;
			for (int i = 0; i < SYS_LINKS; i++) sysCtrl_reg[i] <= srls_pkg::REG_RESET;
			for (int i = 0; i < PROC_LINKS; i++) procCtrl_reg[i] <= srls_pkg::REG_RESET;
		end
		else
		begin
			nodeId_reg <= nodeId_next;
			tableLow_reg <= tableLow_next;
			tableHigh_reg <= tableHigh_next;
			spareA_reg <= spareA_next;
			spareB_reg <= spareB_next;
			for (int i = 0; i < SYS_LINKS; i++) sysCtrl_reg[i] <= sysCtrl_next[i];
			for (int i = 0; i < PROC_LINKS; i++) procCtrl_reg[i] <= procCtrl_next[i];
		end
	end

	// ********************************
	// Debug event capture
	// ********************************
	logic [31:0] debugOrigin_reg, debugOrigin_next;

	// Latest event overwrites; the record is read-only, so software cannot clear it
	always_comb
	begin
		debugOrigin_next = debugOrigin_reg;
		if (debugEvent)
		begin
			debugOrigin_next = debugSource;
		end
	end

	// Captured source register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			debugOrigin_reg <= srls_pkg::REG_RESET;
		end
		else
		begin
			debugOrigin_reg <= debugOrigin_next;
		end
	end

	// ********************************
	// Link status words
	// ********************************
	logic [31:0] sysWord [SYS_LINKS];
	logic [31:0] procWord [PROC_LINKS];

	// Status words are live levels; only the control bits are stored here
	for (genvar g = 0; g < SYS_LINKS; g++)
	begin : gSys
		srls_link_status uStat (
			.srcKind(sysSrcKind[2*g +: 2]),
			.destLink(sysDestLink[8*g +: 8]),
			.junk(sysJunk[g]),
			.destBusy(sysDestBusy[g]),
			.srcBusy(sysSrcBusy[g]),
			.ctrl(sysCtrl_reg[g]),
			.word(sysWord[g])
		);
	end
	// Processor links reuse the builder; their direction bits are masked at write
	for (genvar g = 0; g < PROC_LINKS; g++)
	begin : gProc
		srls_link_status uStat (
			.srcKind(procSrcKind[2*g +: 2]),
			.destLink(procDestLink[8*g +: 8]),
			.junk(procJunk[g]),
			.destBusy(procDestBusy[g]),
			.srcBusy(procSrcBusy[g]),
			.ctrl(procCtrl_reg[g]),
			.word(procWord[g])
		);
	end

	// ********************************
	// Read path
	// ********************************
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	// Unmapped numbers read zero
	always_comb
	begin
		rvalid_next = cfgRead;
		rdata_next = rdata_reg;
		if (cfgRead)
		begin
			rdata_next = 32'h00000000;
			case (cfgAddr)
				srls_pkg::REG_NODE_ID: rdata_next = nodeId_reg;
				srls_pkg::REG_TEST_PORT_IDENTITY:
					rdata_next = {srls_pkg::ID_VERSION, srls_pkg::ID_PART,
						srls_pkg::ID_MAKER, srls_pkg::ID_MARK};
				srls_pkg::REG_USER_CODE:
					rdata_next = {otpUsercode, srls_pkg::REVISION_CODE};
				srls_pkg::REG_DIRECTION_TABLE_LOW: rdata_next = tableLow_reg;
				srls_pkg::REG_DIRECTION_TABLE_HIGH: rdata_next = tableHigh_reg;
				srls_pkg::REG_SPARE_CONTROL_A: rdata_next = spareA_reg;
				srls_pkg::REG_SPARE_CONTROL_B: rdata_next = spareB_reg;
				srls_pkg::REG_DEBUG_EVENT_ORIGIN: rdata_next = debugOrigin_reg;
				default:
				begin
					for (int i = 0; i < SYS_LINKS; i++)
						if (sysHit[i])
							rdata_next = sysWord[i];
					for (int i = 0; i < PROC_LINKS; i++)
						if (procHit[i])
							rdata_next = procWord[i];
				end
			endcase
		end
	end

	// ********************************
	// Routing
	// ********************************
	logic pickLocal;
	logic [3:0] pickDir;
	logic routeValid_reg, routeValid_next;
	logic routeLocal_reg, routeLocal_next;
	logic [3:0] routeDir_reg, routeDir_next;

	srls_route_pick uPick (
		.destId(routeDest),
		.nodeId(nodeId_reg[srls_pkg::ID_W-1:0]),
		.tableLow(tableLow_reg),
		.tableHigh(tableHigh_reg),
		.isLocal(pickLocal),
		.direction(pickDir)
	);

	// One-cycle decision; result held until next request
	always_comb
	begin
		routeValid_next = routeReq;
		routeLocal_next = routeLocal_reg;
		routeDir_next = routeDir_reg;
		if (routeReq)
		begin
			routeLocal_next = pickLocal;
			routeDir_next = pickLocal ? 4'h0 : pickDir;
		end
	end

	// Read answer register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_reg <= srls_pkg::REG_RESET;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Route answer register; direction and locality hold until the next request
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			routeValid_reg <= 1'b0;
			routeLocal_reg <= 1'b0;
			routeDir_reg <= 4'h0;
		end
		else
		begin
			routeValid_reg <= routeValid_next;
			routeLocal_reg <= routeLocal_next;
			routeDir_reg <= routeDir_next;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Each top output is a flip-flop with no logic after it
	assign cfgRdata = rdata_reg;
	assign cfgRvalid = rvalid_reg;
	assign routeValid = routeValid_reg;
	assign routeLocal = routeLocal_reg;
	assign routeDir = routeDir_reg;

	// ********************************
	// Control field fan-out
	// ********************************
	// Control fields fanned out to the switch
	for (genvar g = 0; g < SYS_LINKS; g++)
	begin : gSysOut
		assign sysLinkDir[srls_pkg::DIR_W*g +: srls_pkg::DIR_W] = ctrlDir(sysCtrl_reg[g]);
		assign sysLinkNet[srls_pkg::NET_W*g +: srls_pkg::NET_W] = ctrlNet(sysCtrl_reg[g]);
	end
	for (genvar g = 0; g < PROC_LINKS; g++)
	begin : gProcOut
		assign procLinkNet[srls_pkg::NET_W*g +: srls_pkg::NET_W] = ctrlNet(procCtrl_reg[g]);
	end
endmodule // srls_switch_regs
`default_nettype wire

// [verification/srls_switch_regs_props.sv]
`timescale 1ns/100ps
`default_nettype none
module srls_switch_regs_props #(
	parameter int SYS_LINKS = 8,
	parameter int PROC_LINKS = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic cfgWrite,
	input wire logic cfgRead,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgWdata,
	input wire logic [31:0] cfgRdata,
	input wire logic cfgRvalid,
	input wire logic [13:0] otpUsercode,
	input wire logic [SYS_LINKS-1:0] sysJunk,
	input wire logic [SYS_LINKS-1:0] sysSrcBusy,
	input wire logic routeReq,
	input wire logic routeValid,
	input wire logic routeLocal,
	input wire logic [3:0] routeDir,
	input wire logic [SYS_LINKS*4-1:0] sysLinkDir,
	input wire logic [PROC_LINKS*2-1:0] procLinkNet
);
	// One clock domain, so clocking and disable are shared
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_RD_ANSWER: assert property (cfgRead |=> cfgRvalid)
		else $error("read not answered next cycle");
	AST_RD_HOLD: assert property (!cfgRead |=> !cfgRvalid && $stable(cfgRdata))
		else $error("read data moved without a read");
	AST_ROUTE_ANSWER: assert property (routeReq |=> routeValid)
		else $error("route not answered next cycle");
	AST_LOCAL_DIR: assert property (routeValid && routeLocal |-> routeDir == 4'h0)
		else $error("local delivery carries a direction");
	AST_SYS_DIR: assert property (cfgWrite && cfgAddr == 8'h20
		|=> sysLinkDir[3:0] == $past(cfgWdata[11:8]))
		else $error("link direction not taken from write");
	AST_PROC_NET: assert property (cfgWrite && cfgAddr == 8'h47
		|=> procLinkNet[15:14] == $past(cfgWdata[5:4]))
		else $error("processor link network not taken");
	AST_USERCODE: assert property (cfgRead && cfgAddr == 8'h0a
		|=> cfgRdata[31:18] == $past(otpUsercode))
		else $error("usercode field wrong");
	AST_JUNK: assert property (cfgRead && cfgAddr == 8'h20
		|=> cfgRdata[2] == $past(sysJunk[0]) && cfgRdata[0] == $past(sysSrcBusy[0]))
		else $error("link status bits wrong");
	AST_RSVD_ZERO: assert property (cfgRead && cfgAddr == 8'h20
		|=> cfgRdata[31:26] == 6'h00 && cfgRdata[15:12] == 4'h0 && cfgRdata[3] == 1'b0)
		else $error("reserved link bits not zero");
endmodule // srls_switch_regs_props
bind srls_switch_regs srls_switch_regs_props #(.SYS_LINKS(SYS_LINKS), .PROC_LINKS(PROC_LINKS))
	props (.clock, .resetn, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgRdata, .cfgRvalid,
	.otpUsercode, .sysJunk, .sysSrcBusy, .routeReq, .routeValid, .routeLocal, .routeDir,
	.sysLinkDir, .procLinkNet);
`default_nettype wire

// [verification/srls_switch_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Switch fabric side: per-link status levels chosen by a pattern
module srls_switch_model #(
	parameter int N = 8
) (
	input wire logic [2:0] pat,
	output logic [N*2-1:0] kind,
	output logic [N*8-1:0] dest,
	output logic [N-1:0] junk,
	output logic [N-1:0] dBusy,
	output logic [N-1:0] sBusy
);
	// Destination number is driven even when idle; the block must hide it then
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			kind[i*2+:2] = 2'(i);
			dest[i*8+:8] = 8'(8'h10 + i);
			junk[i] = pat[2];
			dBusy[i] = pat[1];
			sBusy[i] = pat[0];
		end
	end
endmodule // srls_switch_model
`default_nettype wire

// [verification/srls_switch_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module srls_switch_regs_tb;
	logic clock = 0, resetn = 0, cfgWrite = 0, cfgRead = 0, debugEvent = 0, routeReq = 0;
	logic [7:0] cfgAddr = 0;
	logic [31:0] cfgWdata = 0, debugSource = 0, cfgRdata;
	logic [15:0] routeDest = 0, sKind, sysLinkNet, procLinkNet;
	logic [13:0] otp = 14'h2a5b;
	logic [2:0] pat = 0;
	logic [63:0] sDest;
	logic [7:0] sJunk, sDBusy, sSBusy;
	logic [31:0] sysLinkDir;
	logic cfgRvalid, routeValid, routeLocal;
	logic [3:0] routeDir;
	int fail_count = 0, cmp_count = 0, cycles = 0;
	srls_switch_model model (.pat(pat), .kind(sKind), .dest(sDest), .junk(sJunk),
		.dBusy(sDBusy), .sBusy(sSBusy));
	srls_switch_regs uut (.clock(clock), .resetn(resetn), .cfgWrite(cfgWrite),
		.cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
		.cfgRvalid(cfgRvalid), .otpUsercode(otp), .debugEvent(debugEvent),
		.debugSource(debugSource), .sysSrcKind(sKind), .sysDestLink(sDest),
		.sysJunk(sJunk), .sysDestBusy(sDBusy), .sysSrcBusy(sSBusy), .procSrcKind(sKind),
		.procDestLink(sDest), .procJunk(sJunk), .procDestBusy(sDBusy),
		.procSrcBusy(sSBusy), .routeReq(routeReq), .routeDest(routeDest),
		.routeValid(routeValid), .routeLocal(routeLocal), .routeDir(routeDir),
		.sysLinkDir(sysLinkDir), .sysLinkNet(sysLinkNet), .procLinkNet(procLinkNet));
	// ********************
	// Clock, timeout, shared tasks
	// ********************
	initial
	begin
		forever #5 clock = ~clock;
	end
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			test_done();
		end
	end
	task test_done();
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	// Idle edge after each strobe keeps one assignment per time step
	task wr(input logic [7:0] a, input logic [31:0] d);
		cfgAddr = a;
		cfgWdata = d;
		cfgWrite = 1;
		@(posedge clock);
		#1 cfgWrite = 0;
		@(posedge clock);
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		cfgAddr = a;
		cfgRead = 1;
		@(posedge clock);
		#1 cfgRead = 0;
		chk({31'h0, cfgRvalid}, 32'h1);
		chk(cfgRdata, e);
		@(posedge clock);
		#1;
	endtask
	task rt(input logic [15:0] d, input logic l, input logic [3:0] e);
		routeDest = d;
		routeReq = 1;
		@(posedge clock);
		#1 routeReq = 0;
		chk({26'h0, routeValid, routeLocal, routeDir}, {26'h0, 1'b1, l, e});
		@(posedge clock);
		#1;
	endtask
	task do_reset();
		resetn = 0;
		repeat (8) @(posedge clock);
		#1 resetn = 1;
	endtask
	// ********************
	// Scenarios
	// ********************
	task s_reset_vals();
		pat = 0;
		rd(8'h0c, 32'h0);
		rd(8'h0d, 32'h0);
		rd(8'h05, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h10, 32'h0);
		chk(sysLinkDir, 32'h0);
	endtask
	// Every dimension hit: table nibble d holds d+8 modulo 16
	task s_route();
		wr(8'h0c, 32'hfedcba98);
		wr(8'h0d, 32'h76543210);
		wr(8'h05, 32'hffff1234);
		rd(8'h0c, 32'hfedcba98);
		rd(8'h0d, 32'h76543210);
		rd(8'h05, 32'h00001234);
		for (int d = 0; d < 16; d++)
			rt(16'h1234 ^ 16'((32'h2 << d) - 1), 1'b0, 4'(d + 8));
		rt(16'h1234, 1'b1, 4'h0);
	endtask
	task s_links();
		for (int p = 4; p <= 7; p++)
		begin
			pat = 3'(p);
			for (int i = 0; i < 8; i++)
			begin
				logic [7:0] dl;
				dl = (pat[1] | pat[0]) ? 8'(8'h10 + i) : 8'h00;
				wr(8'(8'h20 + i), 32'hffffffff);
				wr(8'(8'h40 + i), 32'hffffffff);
				rd(8'(8'h20 + i), {6'h0, 2'(i), dl, 8'h0f, 4'h3, 1'b0, pat});
				rd(8'(8'h40 + i), {6'h0, 2'(i), dl, 10'h0, 2'h3, 1'b0, pat});
				chk({28'h0, sysLinkDir[i*4+:4]}, 32'hf);
				chk({28'h0, sysLinkNet[i*2+:2], procLinkNet[i*2+:2]}, 32'hf);
			end
		end
	endtask
	task s_fixed();
		wr(8'h0a, 32'h0);
		wr(8'h09, 32'h0);
		rd(8'h0a, {otp, srls_pkg::REVISION_CODE});
		rd(8'h09, {srls_pkg::ID_VERSION, srls_pkg::ID_PART, srls_pkg::ID_MAKER,
			srls_pkg::ID_MARK});
		rd(8'h30, 32'h0);
		wr(8'h11, 32'hffffffff);
		rd(8'h11, 32'h3);
		debugSource = 32'h00000abc;
		debugEvent = 1;
		@(posedge clock);
		#1 debugEvent = 0;
		wr(8'h1f, 32'h0);
		rd(8'h1f, 32'h00000abc);
	endtask
	initial
	begin
		do_reset();
		s_reset_vals();
		s_route();
		s_links();
		s_fixed();
		do_reset();
		s_reset_vals();
		test_done();
	end
endmodule // srls_switch_regs_tb
`default_nettype wire
